// ===== mcph_consts.vh
// constants for the module/carrier power handshake block
// assumes a 100 MHz logic clock; included by mcph_top.v and mcph_debounce.v
// Overview of operation
// - raise carrier power enable only after all module boot supplies are good
// - no boot while carrier reset request held; order power, enable, release, boot
// - supply fault low blocks all supply enables and halts the sequence
// - carrier standby output low in standby state, high otherwise
// - low lid input means lid closed, may start sleep; debounced
// - sleep request is active low level, floated when idle, debounced here
// - boot select low asks for SD card boot; sampled to pick source
// - charger present input low means charger DC input present
// - battery low input low means battery low; floating reads high
// - sideband wake input is a wake source from reduced power
// - drive a PWM output whose duty sets backlight level
// - hold reset output to carrier after enable until carrier power settles
// - boot select high or floating selects on-module eMMC boot
// - reset request low forces a module reset; floated otherwise
`ifndef MCPH_CONSTS_VH
`define MCPH_CONSTS_VH

`define MCPH_CLK_PERIOD_NS 10
// carrier power settle time after enable, in microseconds
`define MCPH_CARRIER_SETTLE_US 10000
`define MCPH_CARRIER_SETTLE_CYC ((`MCPH_CARRIER_SETTLE_US * 1000) / `MCPH_CLK_PERIOD_NS)
// debounce time on human-facing inputs, in microseconds
`define MCPH_DEBOUNCE_US 10000
`define MCPH_DEBOUNCE_CYC ((`MCPH_DEBOUNCE_US * 1000) / `MCPH_CLK_PERIOD_NS)

// register offsets
`define MCPH_REG_CTRL 4'h0
`define MCPH_REG_STATUS 4'h1
`define MCPH_REG_IRQ_STAT 4'h2
`define MCPH_REG_IRQ_MASK 4'h3
`define MCPH_REG_PWM_DUTY 4'h4
`define MCPH_REG_PWM_PERIOD 4'h5

// control fields
`define MCPH_CTRL_STANDBY_BIT 0
`define MCPH_CTRL_RESET 8'h00
`define MCPH_PWM_DUTY_RESET 8'h00
`define MCPH_PWM_PERIOD_RESET 8'hff
`define MCPH_IRQ_MASK_RESET 8'h00

// interrupt event bits
`define MCPH_EV_LID_CLOSE 0
`define MCPH_EV_SLEEP 1
`define MCPH_EV_BATTERY_LOW_N 2
`define MCPH_EV_CHARGER 3
`define MCPH_EV_WAKE 4
`define MCPH_EV_FAULT 5
`define MCPH_EV_BOOT 6
`define MCPH_NUM_EV 7

`endif

// ===== mcph_debounce.v
// two-stage synchroniser followed by an optional stable-time filter
// assumes one clock; input may come from any domain
`timescale 1ns/1ps
`include "mcph_consts.vh"
module mcph_debounce #(
  parameter CNT_W = 24,
  parameter [23:0] STABLE_CYC = 24'd1
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire raw_i,
  output reg clean_o
);
  reg meta_r;
  reg sync_r;
  reg [CNT_W-1:0] cnt_r;

  // synchroniser; inputs idle high (pulled up), so reset to one
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= raw_i;
      sync_r <= meta_r;
    end
  end

  // accept a new level only after it holds for STABLE_CYC cycles
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= {CNT_W{1'b0}};
      clean_o <= 1'b1;
    end else if (sync_r == clean_o) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (cnt_r >= STABLE_CYC[CNT_W-1:0] - 1'b1) begin
      cnt_r <= {CNT_W{1'b0}};
      clean_o <= sync_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// ===== mcph_top.v
// power and boot handshake sequencer between module and carrier
// assumes one 100 MHz clock; all carrier pins are asynchronous and pulled up
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "mcph_consts.vh"
module mcph_top #(
  parameter [23:0] SETTLE_CYC = `MCPH_CARRIER_SETTLE_CYC,
  parameter [23:0] DEBOUNCE_CYC = `MCPH_DEBOUNCE_CYC
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire module_supplies_good_i,
  input wire input_supply_fault_n_i,
  input wire reset_request_n_i,
  input wire lid_closed_n_i,
  input wire sleep_request_n_i,
  input wire battery_low_n_i,
  input wire charger_present_n_i,
  input wire sd_boot_select_n_i,
  input wire sideband_wake_n_i,
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output wire irq_o,
  output reg supplies_enable_o,
  output reg carrier_power_enable_o,
  output reg carrier_reset_n_o,
  output reg carrier_standby_n_o,
  output reg boot_start_o,
  output reg boot_from_sd_o,
  output reg backlight_dimming_out_o
);
  // one-hot sequencer states
  localparam [5:0] ST_OFF = 6'h01;
  localparam [5:0] ST_SUPPLY = 6'h02;
  localparam [5:0] ST_SETTLE = 6'h04;
  localparam [5:0] ST_WAIT_REL = 6'h08;
  localparam [5:0] ST_RUN = 6'h10;
  localparam [5:0] ST_STANDBY = 6'h20;

  wire fault_n_s;
  wire rstreq_n_s;
  wire good_s;
  wire lid_n_s;
  wire sleep_n_s;
  wire battery_low_n_n_s;
  wire charger_n_s;
  wire bootsel_n_s;
  wire wake_n_s;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [23:0] settle_r;
  reg [1:0] warm_r;
  reg [7:0] ctrl_r;
  reg [`MCPH_NUM_EV-1:0] irq_stat_r;
  reg [`MCPH_NUM_EV-1:0] irq_mask_r;
  reg [7:0] duty_r;
  reg [7:0] period_r;
  reg [7:0] pwm_cnt_r;
  reg [`MCPH_NUM_EV-1:0] ev_lvl_prev_r;
  wire [`MCPH_NUM_EV-1:0] ev_lvl;
  wire [`MCPH_NUM_EV-1:0] ev_pulse;
  wire sleep_want;
  wire [8:0] raw_bus;
  wire [8:0] clean_bus;

  // carrier pins; fault, reset request, battery low, charger, strap, wake and supply good are
  // only synchronised, lid and sleep inputs also debounced
  assign raw_bus = {module_supplies_good_i, sideband_wake_n_i, sd_boot_select_n_i, charger_present_n_i,
    battery_low_n_i, sleep_request_n_i, lid_closed_n_i, reset_request_n_i, input_supply_fault_n_i};
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_in
      mcph_debounce #(
        .CNT_W(24),
        .STABLE_CYC((gi == 2 || gi == 3) ? DEBOUNCE_CYC : 24'd1)
      ) u_in (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .raw_i(raw_bus[gi]),
        .clean_o(clean_bus[gi])
      );
    end
  endgenerate
  assign fault_n_s = clean_bus[0];
  assign rstreq_n_s = clean_bus[1];
  assign lid_n_s = clean_bus[2];
  assign sleep_n_s = clean_bus[3];
  assign battery_low_n_n_s = clean_bus[4];
  assign charger_n_s = clean_bus[5];
  assign bootsel_n_s = clean_bus[6];
  assign wake_n_s = clean_bus[7];
  assign good_s = clean_bus[8];

  // standby is requested by lid closure, sleep input or software
  assign sleep_want = !lid_n_s || !sleep_n_s || ctrl_r[`MCPH_CTRL_STANDBY_BIT];

  // next state; fault or warm-up dominates every other condition, then supply loss, then reset request in run/standby
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (fault_n_s)
          state_nxt = ST_SUPPLY;
      end
      ST_SUPPLY: begin
        if (good_s)
          state_nxt = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (settle_r >= SETTLE_CYC - 24'd1)
          state_nxt = ST_WAIT_REL;
      end
      ST_WAIT_REL: begin
        if (rstreq_n_s)
          state_nxt = ST_RUN;
      end
      ST_RUN: begin
        // a held wake keeps the module running, so the state cannot toggle every cycle
        if (sleep_want && wake_n_s)
          state_nxt = ST_STANDBY;
      end
      ST_STANDBY: begin
        if (!wake_n_s || (!sleep_want && lid_n_s))
          state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (!fault_n_s || warm_r != 2'h3)
      state_nxt = ST_OFF;
    else if (!good_s && state_r != ST_OFF && state_r != ST_SUPPLY)
      state_nxt = ST_SUPPLY;
    else if (!rstreq_n_s && (state_r == ST_RUN || state_r == ST_STANDBY))
      state_nxt = ST_WAIT_REL;
  end

  // hold the sequencer off until the synchronisers carry real pin levels;
  // they reset to the idle level, which would fake supplies good and no fault
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  // state register and settle counter
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_OFF;
      settle_r <= 24'd0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_SETTLE && state_nxt == ST_SETTLE)
        settle_r <= settle_r + 24'd1;
      else
        settle_r <= 24'd0;
    end
  end

  // registered pin outputs; boot source latched as boot begins
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      supplies_enable_o <= 1'b0;
      carrier_power_enable_o <= 1'b0;
      carrier_reset_n_o <= 1'b0;
      carrier_standby_n_o <= 1'b1;
      boot_start_o <= 1'b0;
      boot_from_sd_o <= 1'b0;
    end else begin
      supplies_enable_o <= (state_nxt != ST_OFF);
      carrier_power_enable_o <= (state_nxt == ST_SETTLE) || (state_nxt == ST_WAIT_REL) ||
        (state_nxt == ST_RUN) || (state_nxt == ST_STANDBY);
      carrier_reset_n_o <= (state_nxt == ST_WAIT_REL) || (state_nxt == ST_RUN) ||
        (state_nxt == ST_STANDBY);
      carrier_standby_n_o <= (state_nxt != ST_STANDBY);
      boot_start_o <= (state_r == ST_WAIT_REL) && (state_nxt == ST_RUN);
      if ((state_r == ST_WAIT_REL) && (state_nxt == ST_RUN))
        boot_from_sd_o <= !bootsel_n_s;
    end
  end

  // event levels; rising edges of these set sticky status bits
  assign ev_lvl[`MCPH_EV_LID_CLOSE] = !lid_n_s;
  assign ev_lvl[`MCPH_EV_SLEEP] = !sleep_n_s;
  assign ev_lvl[`MCPH_EV_BATTERY_LOW_N] = !battery_low_n_n_s;
  assign ev_lvl[`MCPH_EV_CHARGER] = !charger_n_s;
  assign ev_lvl[`MCPH_EV_WAKE] = !wake_n_s;
  assign ev_lvl[`MCPH_EV_FAULT] = !fault_n_s;
  assign ev_lvl[`MCPH_EV_BOOT] = boot_start_o;
  assign ev_pulse = ev_lvl & ~ev_lvl_prev_r;

  // register file; a set in the clearing cycle wins over the clear
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= `MCPH_CTRL_RESET;
      irq_mask_r <= {`MCPH_NUM_EV{1'b0}};
      irq_stat_r <= {`MCPH_NUM_EV{1'b0}};
      duty_r <= `MCPH_PWM_DUTY_RESET;
      period_r <= `MCPH_PWM_PERIOD_RESET;
      ev_lvl_prev_r <= {`MCPH_NUM_EV{1'b0}};
    end else begin
      ev_lvl_prev_r <= ev_lvl;
      if (reg_wr_i && reg_addr_i == `MCPH_REG_CTRL)
        ctrl_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `MCPH_REG_IRQ_MASK)
        irq_mask_r <= reg_wdata_i[`MCPH_NUM_EV-1:0];
      if (reg_wr_i && reg_addr_i == `MCPH_REG_PWM_DUTY)
        duty_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `MCPH_REG_PWM_PERIOD)
        period_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `MCPH_REG_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~reg_wdata_i[`MCPH_NUM_EV-1:0]) | ev_pulse;
      else
        irq_stat_r <= irq_stat_r | ev_pulse;
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // read data one cycle after the strobe; unmapped reads give zero
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `MCPH_REG_CTRL: reg_rdata_o <= ctrl_r;
        `MCPH_REG_STATUS: reg_rdata_o <= {boot_from_sd_o, !wake_n_s, !charger_n_s, !battery_low_n_n_s,
          !sleep_n_s, !lid_n_s, !rstreq_n_s, !fault_n_s};
        `MCPH_REG_IRQ_STAT: reg_rdata_o <= {1'b0, irq_stat_r};
        `MCPH_REG_IRQ_MASK: reg_rdata_o <= {1'b0, irq_mask_r};
        `MCPH_REG_PWM_DUTY: reg_rdata_o <= duty_r;
        `MCPH_REG_PWM_PERIOD: reg_rdata_o <= period_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // backlight pwm; off outside run so the panel stays dark in standby
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_cnt_r <= 8'h00;
      backlight_dimming_out_o <= 1'b0;
    end else begin
      if (pwm_cnt_r >= period_r)
        pwm_cnt_r <= 8'h00;
      else
        pwm_cnt_r <= pwm_cnt_r + 8'h01;
      backlight_dimming_out_o <= (state_nxt == ST_RUN) && (pwm_cnt_r < duty_r);
    end
  end
endmodule

// ===== mcph_carrier_model.sv
// carrier supervisor model: supply fault line, rail ramp and reset request
// assumes open-drain lines that the module pulls up when released
`timescale 1ns/1ps
module mcph_carrier_model #(
  parameter RAIL_CYC = 6
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire carrier_power_enable_i,
  input wire fault_i,
  input wire hold_reset_i,
  output wire input_supply_fault_n_o,
  output wire reset_request_n_o,
  output reg rails_on_o
);
  reg [7:0] ramp_r;
  // released fault line reads high through the module pull-up
  assign input_supply_fault_n_o = !fault_i;
  // rails never ramp ahead of the enable; a larger RAIL_CYC gives a slow carrier
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ramp_r <= 8'h00;
      rails_on_o <= 1'b0;
    end else if (!carrier_power_enable_i || fault_i) begin
      ramp_r <= 8'h00;
      rails_on_o <= 1'b0;
    end else if (ramp_r < RAIL_CYC) begin
      ramp_r <= ramp_r + 8'h01;
    end else begin
      rails_on_o <= 1'b1;
    end
  end
  // request released only as the last step, acting as carrier power good
  assign reset_request_n_o = rails_on_o && !hold_reset_i;
endmodule

// ===== mcph_top_props.sv
// checker for the power handshake sequencer
// assumes it sees mcph_top ports only and shares its SETTLE_CYC
`timescale 1ns/1ps
module mcph_top_props #(
  parameter [23:0] SETTLE_CYC = 24'd8
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire module_supplies_good_i,
  input wire input_supply_fault_n_i,
  input wire sd_boot_select_n_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire supplies_enable_o,
  input wire carrier_power_enable_o,
  input wire carrier_reset_n_o,
  input wire carrier_standby_n_o,
  input wire boot_start_o,
  input wire boot_from_sd_o,
  input wire backlight_dimming_out_o
);
  reg [23:0] hold_cnt_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // cycles with the carrier enabled while its reset is still held
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) hold_cnt_r <= 24'h000000;
    else if (carrier_power_enable_o && !carrier_reset_n_o) hold_cnt_r <= hold_cnt_r + 24'h000001;
    else hold_cnt_r <= 24'h000000;
  end
  a_enable_after_good: assert property ($rose(carrier_power_enable_o) |->
    $past(module_supplies_good_i, 3) && supplies_enable_o)
    else $error("carrier enable rose without module supplies good");
  a_fault_blocks_all: assert property ((!input_supply_fault_n_i) [*5] |=>
    !supplies_enable_o && !carrier_power_enable_o)
    else $error("supplies enabled during supply fault");
  a_settle_hold: assert property ($rose(carrier_reset_n_o) |-> hold_cnt_r >= SETTLE_CYC - 24'd1)
    else $error("carrier reset released too early");
  a_boot_order: assert property (boot_start_o |-> carrier_power_enable_o && carrier_reset_n_o)
    else $error("boot before enable and reset release");
  a_boot_pulse: assert property (boot_start_o |=> !boot_start_o)
    else $error("boot start longer than one cycle");
  a_boot_source: assert property ($rose(boot_start_o) |=>
    boot_from_sd_o == !sd_boot_select_n_i)
    else $error("boot source differs from select line");
  a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_backlight_run: assert property (!carrier_reset_n_o |-> !backlight_dimming_out_o)
    else $error("backlight active before run");
  a_standby_powered: assert property (!carrier_standby_n_o |-> carrier_reset_n_o && supplies_enable_o)
    else $error("standby shown while not running");
  c_boot: cover property (boot_start_o);
  c_standby: cover property (!carrier_standby_n_o);
  c_release: cover property ($rose(carrier_reset_n_o));
endmodule
bind mcph_top mcph_top_props #(.SETTLE_CYC(SETTLE_CYC)) mcph_top_props_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .module_supplies_good_i(module_supplies_good_i), .input_supply_fault_n_i(input_supply_fault_n_i),
  .sd_boot_select_n_i(sd_boot_select_n_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .supplies_enable_o(supplies_enable_o), .carrier_power_enable_o(carrier_power_enable_o),
  .carrier_reset_n_o(carrier_reset_n_o), .carrier_standby_n_o(carrier_standby_n_o), .boot_start_o(boot_start_o),
  .boot_from_sd_o(boot_from_sd_o), .backlight_dimming_out_o(backlight_dimming_out_o));

// ===== mcph_top_tb.sv
// self-checking bench for mcph_top beside a carrier supervisor model
// assumes settle of 8 and debounce of 4 cycles to keep the run short
`timescale 1ns/1ps
module mcph_top_tb;
  reg clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg good = 1'b0, fault = 1'b1, hold = 1'b1, lid_n = 1'b1, sleep_n = 1'b1, bat_n = 1'b1;
  reg chg_n = 1'b1, sd_n = 1'b0, wake_n = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  wire [7:0] rdata;
  wire irq, sup_en, cpe, rst_n, stby_n, boot, from_sd, pwm, fault_n, req_n;
  int err_total = 0, check_count = 0, boots = 0, cycles = 0, k, n;

  mcph_top #(.SETTLE_CYC(24'd8), .DEBOUNCE_CYC(24'd4)) mcph_top_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .module_supplies_good_i(good), .input_supply_fault_n_i(fault_n), .reset_request_n_i(req_n),
    .lid_closed_n_i(lid_n), .sleep_request_n_i(sleep_n), .battery_low_n_i(bat_n), .charger_present_n_i(chg_n),
    .sd_boot_select_n_i(sd_n), .sideband_wake_n_i(wake_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .irq_o(irq), .supplies_enable_o(sup_en),
    .carrier_power_enable_o(cpe), .carrier_reset_n_o(rst_n), .carrier_standby_n_o(stby_n),
    .boot_start_o(boot), .boot_from_sd_o(from_sd), .backlight_dimming_out_o(pwm));
  mcph_carrier_model #(.RAIL_CYC(6)) mcph_carrier_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .carrier_power_enable_i(cpe), .fault_i(fault), .hold_reset_i(hold), .input_supply_fault_n_o(fault_n),
    .reset_request_n_o(req_n), .rails_on_o());

  always #5 clk_i = ~clk_i;
  // boot pulse count and a hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (boot === 1'b1) boots++;
    if (cycles == 4000) begin
      err_total++;
      tally_and_finish;
    end
  end
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask
  task tally_and_finish;
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    cyc(1);
    chk("standby idle", 8'h01, stby_n);
    chk("no early enable", 8'h00, {sup_en, cpe});
    rd(4'h5, 8'hff, "period reset");
    rd(4'h3, 8'h00, "mask reset");
    rd(4'hf, 8'h00, "unmapped");
    @(posedge clk_i);
    good <= 1'b1;
    cyc(20);
    chk("supplies in fault", 8'h00, {sup_en, cpe});
    @(posedge clk_i);
    good <= 1'b0;
    fault <= 1'b0;
    cyc(10);
    chk("supplies no good", 8'h02, {sup_en, cpe});
    @(posedge clk_i);
    good <= 1'b1;
    for (k = 0; k < 20 && cpe !== 1'b1; k++) cyc(1);
    chk("carrier reset held", 8'h02, {cpe, rst_n});
    cyc(20);
    chk("no boot in request", 8'h00, boots);
    @(posedge clk_i);
    hold <= 1'b0;
    for (k = 0; k < 30 && boots == 0; k++) cyc(1);
    cyc(1);
    chk("sd boot", 8'h11, {boots[3:0], 3'b000, from_sd});
    wr(4'h3, 8'h01);
    @(posedge clk_i);
    lid_n <= 1'b0;
    cyc(12);
    chk("lid standby", 8'h01, {stby_n, irq});
    rd(4'h1, 8'h84, "lid status");
    wr(4'h2, 8'h01);
    cyc(1);
    chk("irq cleared", 8'h00, irq);
    @(posedge clk_i);
    lid_n <= 1'b1;
    cyc(12);
    chk("lid open", 8'h01, stby_n);
    @(posedge clk_i);
    sleep_n <= 1'b0;
    cyc(12);
    chk("sleep standby", 8'h00, stby_n);
    @(posedge clk_i);
    wake_n <= 1'b0;
    for (k = 0; k < 8 && stby_n !== 1'b1; k++) cyc(1);
    chk("wake", 8'h01, stby_n);
    @(posedge clk_i);
    sleep_n <= 1'b1;
    wake_n <= 1'b1;
    bat_n <= 1'b0;
    chg_n <= 1'b0;
    cyc(12);
    rd(4'h1, 8'hb0, "battery status");
    chk("masked irq", 8'h00, irq);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h01, "ctrl standby");
    chk("soft standby", 8'h00, stby_n);
    wr(4'h0, 8'h00);
    cyc(2);
    chk("soft run", 8'h01, stby_n);
    wr(4'h4, 8'h02);
    wr(4'h5, 8'h03);
    cyc(260);
    n = 0;
    for (k = 0; k < 8; k++) begin
      cyc(1);
      if (pwm === 1'b1) n++;
    end
    chk("pwm high cycles", 8'h04, n);
    @(posedge clk_i);
    hold <= 1'b1;
    sd_n <= 1'b1;
    cyc(10);
    @(posedge clk_i);
    hold <= 1'b0;
    for (k = 0; k < 30 && boots < 2; k++) cyc(1);
    cyc(1);
    chk("emmc reboot", 8'h20, {boots[3:0], 3'b000, from_sd});
    @(posedge clk_i);
    fault <= 1'b1;
    cyc(10);
    chk("fault in run", 8'h00, {sup_en, cpe, rst_n});
    tally_and_finish;
  end
endmodule
